// File: verilog/svmc_pkg.sv
// Package for the supply voltage monitor control block
package svmc_pkg;
  // Register addresses in the second I/O bank
  localparam logic [8:0] SVMC_CTRL_ADDR = 9'h1e3;
  localparam logic [8:0] SVMC_STAT_ADDR = 9'h1e4;
  localparam logic [8:0] SVMC_TRIM_ADDR = 9'h1eb;
  localparam logic [8:0] SVMC_BANK_BIT = 9'h100;
  // Field positions
  localparam int SVMC_LEVEL_LSB = 4;
  localparam int SVMC_DUTY_LSB = 6;
  localparam int SVMC_UNDER_BIT = 1;
  localparam int SVMC_PRECISE_BIT = 0;
  // Reset values and masks
  localparam logic [7:0] SVMC_CTRL_RST = 8'h00;
  localparam logic [7:0] SVMC_TRIM_RST = 8'h00;
  localparam logic [7:0] SVMC_CTRL_MASK = 8'h37;
  localparam logic [7:0] SVMC_TRIM_MASK = 8'hc0;
  // Reset-level codes
  localparam logic [1:0] SVMC_LEVEL_2V7 = 2'h0;
  localparam logic [1:0] SVMC_LEVEL_3V = 2'h1;
  localparam logic [1:0] SVMC_LEVEL_5V = 2'h2;
  localparam logic [1:0] SVMC_LEVEL_OFF = 2'h3;
  // Lowest usable trip code
  localparam logic [2:0] SVMC_TRIP_MIN = 3'h4;
  // Duty ratio periods, in 32 kHz periods
  localparam logic [9:0] SVMC_DUTY_P0 = 10'h080;
  localparam logic [9:0] SVMC_DUTY_P1 = 10'h200;
  localparam logic [9:0] SVMC_DUTY_P2 = 10'h020;
  localparam logic [9:0] SVMC_DUTY_P3 = 10'h008;
  // Settle edges after interrupt sync before sampling
  localparam logic [1:0] SVMC_SETTLE_EDGES = 2'h2;

  typedef struct packed {
    logic [1:0] level;
    logic [2:0] trip;
    logic [1:0] duty;
  } svmc_cfg_type;

  typedef struct packed {
    logic under;
    logic precise;
  } svmc_cmp_type;
endpackage : svmc_pkg

// File: verilog/svmc_duty.sv
// Sleep duty-cycle sequencer for the monitor comparators
`timescale 1ns/1ps
module svmc_duty
  import svmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] duty,
  input wire logic sleep,
  input wire logic wake_sync,
  input wire logic lf_rise,
  output logic mon_on,
  output logic sample
);
  logic [9:0] cnt_r;
  logic [1:0] edge_r;
  logic waking_r;

  function automatic logic [9:0] period_of(input logic [1:0] d);
    unique case (d)
      2'h0: period_of = SVMC_DUTY_P0;
      2'h1: period_of = SVMC_DUTY_P1;
      2'h2: period_of = SVMC_DUTY_P2;
      2'h3: period_of = SVMC_DUTY_P3;
    endcase
  endfunction : period_of

  // One on-period out of each duty period in sleep
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 10'h000;
    end else if (!sleep) begin
      cnt_r <= 10'h000;
    end else if (lf_rise) begin
      cnt_r <= (cnt_r >= period_of(duty) - 10'h001) ? 10'h000 : cnt_r + 10'h001; // see [R9] see [R10]
    end
  end

  // Wake sample on second 32 kHz rise after sync
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waking_r <= 1'b0;
      edge_r <= 2'h0;
    end else if (wake_sync) begin
      waking_r <= 1'b1;
      edge_r <= 2'h0;
    end else if (waking_r && lf_rise) begin
      edge_r <= edge_r + 2'h1;
      if (edge_r + 2'h1 == SVMC_SETTLE_EDGES) begin
        waking_r <= 1'b0; // see [R11]
      end
    end
  end

  assign mon_on = !sleep || (cnt_r == 10'h000);
  assign sample = waking_r && lf_rise && (edge_r + 2'h1 == SVMC_SETTLE_EDGES); // see [R11]
endmodule : svmc_duty

// File: verilog/svmc_top.sv
// Supply voltage monitor control registers and comparator status
// Notes on behaviour
// [R1] Reset-level field bits 5:4 pick 2.7 V, 3 V or 5 V reset range.
// [R2] Code 11 blocks resets; status still shows comparator at 3 V range.
// [R3] Firmware selects the 5 V range before running above 12 MHz.
// [R4] Trip select bits 2:0; codes below 100 reserved, higher codes raise trip.
// [R5] Status bit 1 shows undervoltage comparator state.
// [R6] Status bit 0 shows precise reset comparator state.
// [R7] Status is read-only, live, upper bits zero, writes ignored.
// [R8] Registers decode only with the extended I/O bank flag set.
// [R9] Trim bits 7:6 set monitor on/off duty ratio in 32 kHz periods.
// [R10] In sleep the monitor runs duty-cycled with longer latency.
// [R11] On wake, comparators sampled on second 32 kHz rise after sync.
// [R12] Reserved control and trim bits ignore writes and read zero.
`timescale 1ns/1ps
module svmc_top
  import svmc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // CPU I/O access
  input wire logic [7:0] IO_ADDR,
  input wire logic EXT_IO_BANK_FLAG,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  // Analog comparators: precise ones, one per reset range, plus the undervoltage comparator
  input wire logic [2:0] PRECISE_CMP_RANGE,
  input wire logic UNDERVOLTAGE_CMP,
  // Sleep sequencing
  input wire logic SLEEP,
  input wire logic WAKE_SYNC,
  input wire logic LF_RISE,
  // Analog controls and reset request
  output logic [1:0] RANGE_SELECT,
  output logic [2:0] TRIP_POINT_SELECT,
  output logic MONITOR_ON,
  output logic PRECISE_RESET_REQ
);
  svmc_cfg_type cfg_r;
  svmc_cmp_type cmp_live;
  svmc_cmp_type cmp_r;
  logic [7:0] rdata_nxt;
  logic mon_on;
  logic sample;
  logic [8:0] full_addr;

  function automatic logic hit(input logic [8:0] a, input logic [8:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  assign full_addr = {EXT_IO_BANK_FLAG, IO_ADDR}; // see [R8]

  // Control and trim writes
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cfg_r <= '0;
    end else if (IO_WR) begin
      if (hit(full_addr, SVMC_CTRL_ADDR)) begin
        cfg_r.level <= IO_WDATA[SVMC_LEVEL_LSB +: 2]; // see [R1] see [R12]
        cfg_r.trip <= IO_WDATA[2:0]; // see [R4]
      end
      if (hit(full_addr, SVMC_TRIM_ADDR)) begin
        cfg_r.duty <= IO_WDATA[SVMC_DUTY_LSB +: 2]; // see [R9] see [R12]
      end
    end
  end

  // Comparator selection; off code watches the 3 V range
  always_comb begin
    unique case (cfg_r.level)
      SVMC_LEVEL_2V7: cmp_live.precise = PRECISE_CMP_RANGE[0]; // see [R1]
      SVMC_LEVEL_3V: cmp_live.precise = PRECISE_CMP_RANGE[1];
      SVMC_LEVEL_5V: cmp_live.precise = PRECISE_CMP_RANGE[2];
      SVMC_LEVEL_OFF: cmp_live.precise = PRECISE_CMP_RANGE[1]; // see [R2]
    endcase
    cmp_live.under = UNDERVOLTAGE_CMP;
  end

  // Held comparator state: live when awake, sampled on wake
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cmp_r <= '0;
    end else if (!SLEEP || sample) begin
      cmp_r <= cmp_live; // see [R11]
    end else if (mon_on) begin
      cmp_r <= cmp_live; // see [R10]
    end
  end

  svmc_duty u_duty (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .duty(cfg_r.duty),
    .sleep(SLEEP),
    .wake_sync(WAKE_SYNC),
    .lf_rise(LF_RISE),
    .mon_on(mon_on),
    .sample(sample)
  );

  // Read mux
  always_comb begin
    rdata_nxt = 8'h00;
    if (hit(full_addr, SVMC_CTRL_ADDR)) begin
      rdata_nxt = {2'h0, cfg_r.level, 1'b0, cfg_r.trip} & SVMC_CTRL_MASK; // see [R12]
    end else if (hit(full_addr, SVMC_STAT_ADDR)) begin
      rdata_nxt[SVMC_UNDER_BIT] = cmp_live.under; // see [R5] see [R7]
      rdata_nxt[SVMC_PRECISE_BIT] = cmp_live.precise; // see [R6]
    end else if (hit(full_addr, SVMC_TRIM_ADDR)) begin
      rdata_nxt = {cfg_r.duty, 6'h00} & SVMC_TRIM_MASK; // see [R12]
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      IO_RDATA <= 8'h00;
    end else if (IO_RD) begin
      IO_RDATA <= rdata_nxt;
    end
  end

  // Reset request from held comparator state
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      PRECISE_RESET_REQ <= 1'b0;
    end else begin
      PRECISE_RESET_REQ <= cmp_r.precise && (cfg_r.level != SVMC_LEVEL_OFF); // see [R2]
    end
  end

  assign RANGE_SELECT = (cfg_r.level == SVMC_LEVEL_OFF) ? SVMC_LEVEL_3V : cfg_r.level;
  assign TRIP_POINT_SELECT = cfg_r.trip; // see [R4]
  assign MONITOR_ON = mon_on; // see [R10]

  // Rises seen since the last wake sync, saturating
  logic [1:0] wake_edges_r;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      wake_edges_r <= 2'h3;
    end else if (WAKE_SYNC) begin
      wake_edges_r <= 2'h0;
    end else if (LF_RISE && wake_edges_r != 2'h3) begin
      wake_edges_r <= wake_edges_r + 2'h1;
    end
  end

  // Reset request and off-code range select
  no_reset_off_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R2]
    (cfg_r.level == SVMC_LEVEL_OFF) |=> !PRECISE_RESET_REQ)
    else $error("reset issued with level off");
  req_tripped_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R1]
    (cmp_r.precise && cfg_r.level != SVMC_LEVEL_OFF) |=> PRECISE_RESET_REQ)
    else $error("reset not issued when tripped");
  req_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R6]
    !cmp_r.precise |=> !PRECISE_RESET_REQ)
    else $error("reset issued without trip");
  off_range_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R2]
    (cfg_r.level == SVMC_LEVEL_OFF) |-> RANGE_SELECT == SVMC_LEVEL_3V)
    else $error("off code not on 3 V range");

  // Register access
  ctrl_bank_wr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R8]
    (IO_WR && !EXT_IO_BANK_FLAG) |=> $stable(cfg_r))
    else $error("config changed outside bank");
  bank_read_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R8]
    (IO_RD && !EXT_IO_BANK_FLAG) |=> IO_RDATA == 8'h00)
    else $error("read data outside bank");
  stat_read_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R5] see [R6] see [R7]
    (IO_RD && hit(full_addr, SVMC_STAT_ADDR)) |=>
    (IO_RDATA == {6'h00, $past(UNDERVOLTAGE_CMP), $past(cmp_live.precise)}))
    else $error("status read wrong");
  stat_upper_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R7]
    (IO_RD && hit(full_addr, SVMC_STAT_ADDR)) |=> IO_RDATA[7:2] == 6'h00)
    else $error("status upper bits set");
  level_off_stat_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R2]
    (IO_RD && hit(full_addr, SVMC_STAT_ADDR) && cfg_r.level == SVMC_LEVEL_OFF) |=>
    IO_RDATA[SVMC_PRECISE_BIT] == $past(PRECISE_CMP_RANGE[1]))
    else $error("off code status not 3 V range");
  stat_write_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R7]
    (IO_WR && hit(full_addr, SVMC_STAT_ADDR)) |=> $stable(cfg_r))
    else $error("status write changed config");
  rdata_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R7]
    !IO_RD |=> $stable(IO_RDATA))
    else $error("read data changed without read");
  ctrl_resv_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R12]
    (IO_RD && hit(full_addr, SVMC_CTRL_ADDR)) |=> (IO_RDATA & ~SVMC_CTRL_MASK) == 8'h00)
    else $error("control reserved bits set");
  trim_resv_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R12]
    (IO_RD && hit(full_addr, SVMC_TRIM_ADDR)) |=> IO_RDATA[5:0] == 6'h00)
    else $error("trim reserved bits set");
  trim_write_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R9]
    (IO_WR && hit(full_addr, SVMC_TRIM_ADDR)) |=> cfg_r.duty == $past(IO_WDATA[7:6]))
    else $error("duty not written");
  level_write_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R1]
    (IO_WR && hit(full_addr, SVMC_CTRL_ADDR)) |=> cfg_r.level == $past(IO_WDATA[5:4]))
    else $error("level not written");
  trip_write_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R4]
    (IO_WR && hit(full_addr, SVMC_CTRL_ADDR)) |=> TRIP_POINT_SELECT == $past(IO_WDATA[2:0]))
    else $error("trip select not written");

  // Sleep and wake sampling
  awake_mon_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R10]
    !SLEEP |-> MONITOR_ON)
    else $error("monitor off while awake");
  awake_track_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R6]
    !SLEEP |=> cmp_r == $past(cmp_live))
    else $error("held state not live while awake");
  sleep_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R10]
    (SLEEP && !mon_on && !sample) |=> $stable(cmp_r))
    else $error("held state changed while monitor off");
  duty_on_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R10]
    (SLEEP && mon_on) |=> cmp_r == $past(cmp_live))
    else $error("held state missed on-period");
  wake_second_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R11]
    (LF_RISE && !WAKE_SYNC && wake_edges_r == SVMC_SETTLE_EDGES - 2'h1) |-> sample)
    else $error("no sample on second rise");
  wake_only_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R11]
    sample |-> (LF_RISE && wake_edges_r == SVMC_SETTLE_EDGES - 2'h1))
    else $error("sample off the second rise");
  wake_capture_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // see [R11]
    sample |=> cmp_r == $past(cmp_live))
    else $error("wake sample not captured");
endmodule : svmc_top

// File: bench/svmc_top_bench.sv
// Self-checking bench for the supply monitor register block
`timescale 1ns/1ps
module svmc_top_bench;
  import svmc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] io_addr = 8'h00;
  logic ext_flag = 1'b0;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [2:0] pcmp = 3'h0;
  logic uv = 1'b0;
  logic sleep = 1'b0;
  logic wake = 1'b0;
  logic lf_rise = 1'b0;
  logic [7:0] io_rdata;
  logic [1:0] range_sel;
  logic [2:0] trip_sel;
  logic mon_on;
  logic rst_req;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int ons;
  int per;
  logic [1:0] rng;

  svmc_top dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .IO_ADDR(io_addr), .EXT_IO_BANK_FLAG(ext_flag),
    .IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .PRECISE_CMP_RANGE(pcmp),
    .UNDERVOLTAGE_CMP(uv), .SLEEP(sleep), .WAKE_SYNC(wake), .LF_RISE(lf_rise), .RANGE_SELECT(range_sel),
    .TRIP_POINT_SELECT(trip_sel), .MONITOR_ON(mon_on), .PRECISE_RESET_REQ(rst_req));

  always #50 clk_sys = ~clk_sys;

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 12000) begin
      fail_count++;
      $display("Error at %0t: run timed out", $time);
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    {ext_flag, io_addr} = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clk_sys);
    io_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] exp, input string what);
    @(negedge clk_sys);
    {ext_flag, io_addr} = a;
    io_rd = 1'b1;
    @(negedge clk_sys);
    io_rd = 1'b0;
    chk(io_rdata, exp, what);
  endtask : rd

  // One-cycle 32 kHz rise pulses
  task automatic lf(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      lf_rise = 1'b1;
      @(negedge clk_sys);
      lf_rise = 1'b0;
    end
  endtask : lf

  initial begin
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    rd(SVMC_CTRL_ADDR, SVMC_CTRL_RST, "ctrl reset");
    rd(SVMC_STAT_ADDR, 8'h00, "status reset");
    rd(SVMC_TRIM_ADDR, SVMC_TRIM_RST, "trim reset");
    $display("Test done: reset values");
    wr(SVMC_CTRL_ADDR, 8'hff);
    rd(SVMC_CTRL_ADDR, 8'h37, "ctrl reserved");
    chk({5'h0, trip_sel}, 8'h07, "trip select");
    wr(SVMC_TRIM_ADDR, 8'hff);
    rd(SVMC_TRIM_ADDR, 8'hc0, "trim reserved");
    wr(SVMC_STAT_ADDR, 8'hff);
    rd(SVMC_STAT_ADDR, 8'h00, "status write");
    wr({1'b0, SVMC_CTRL_ADDR[7:0]}, 8'h15);
    rd(SVMC_CTRL_ADDR, 8'h37, "low bank write");
    rd({1'b0, SVMC_CTRL_ADDR[7:0]}, 8'h00, "low bank read");
    $display("Test done: access rules");
    for (int l = 0; l < 4; l++) begin
      rng = (l == 3) ? SVMC_LEVEL_3V : l[1:0];
      wr(SVMC_CTRL_ADDR, {2'h0, l[1:0], 1'b0, SVMC_TRIP_MIN});
      chk({6'h0, range_sel}, {6'h0, rng}, "range select");
      pcmp = 3'h1 << rng;
      uv = l[0];
      repeat (2) @(negedge clk_sys);
      rd(SVMC_STAT_ADDR, {6'h0, uv, 1'b1}, "status tripped");
      chk({7'h0, rst_req}, {7'h0, l != 3}, "reset request");
      pcmp = ~(3'h1 << rng);
      repeat (2) @(negedge clk_sys);
      rd(SVMC_STAT_ADDR, {6'h0, uv, 1'b0}, "status clear");
      chk({7'h0, rst_req}, 8'h00, "reset released");
    end
    $display("Test done: levels and status");
    pcmp = 3'h0;
    for (int d = 0; d < 4; d++) begin
      per = (d == 0) ? 128 : (d == 1) ? 512 : (d == 2) ? 32 : 8;
      wr(SVMC_TRIM_ADDR, {d[1:0], 6'h00});
      chk({7'h0, mon_on}, 8'h01, "awake monitor");
      sleep = 1'b1;
      ons = 0;
      repeat (2 * per) begin
        lf(1);
        ons += int'(mon_on);
      end
      chk(ons[7:0], 8'h02, "duty ratio");
      sleep = 1'b0;
    end
    $display("Test done: sleep duty");
    wr(SVMC_CTRL_ADDR, {2'h0, SVMC_LEVEL_2V7, 4'h4});
    wr(SVMC_TRIM_ADDR, 8'h40);
    sleep = 1'b1;
    lf(2);
    pcmp = 3'h1;
    repeat (3) @(negedge clk_sys);
    chk({7'h0, rst_req}, 8'h00, "held in sleep");
    wake = 1'b1;
    @(negedge clk_sys);
    wake = 1'b0;
    lf(1);
    chk({7'h0, rst_req}, 8'h00, "first rise");
    lf(1);
    @(negedge clk_sys);
    chk({7'h0, rst_req}, 8'h01, "second rise");
    sleep = 1'b0;
    $display("Test done: wake sampling");
    summarize();
  end
endmodule : svmc_top_bench
